// File: logic/sba_defs.svh
// Constants for the bus arbitration and reset block.
// Operation
// [R1] Crystal input divided by twelve gives the interval timer clock.
// [R2] DMA clock comes from the crystal or a selected division of the processor clock.
// [R3] Processor reset output is synchronous to the processor clock, to CPU only.
// [R4] Board-wide reset has processor reset timing but only after supply_ok was low.
// [R5] Bus-release request to the CPU is synchronous to the processor clock.
// [R6] CPU drives bus-release acknowledge synchronously; it is read without synchroniser.
// [R7] Local requests arbitrate against each other, the DMA controllers and the CPU.
// [R8] A local master gets the bus when its grant goes low.
// [R9] Two more request and grant pairs serve up to three local masters.
// [R10] With preemption enabled an unmasked DMA request removes the local master.
// [R11] DMA-owner output is low while DMA or an ISA master owns the bus.
// [R12] During reset the DMA-owner pin is an input selecting the upper ISA address.
// [R13] Copyback window forces the bus-release request low for four clocks.
// [R14] Copyback during a DMA cycle floats address lines A8:9 and A17:23.
// [R15] An ISA master wins via a DMA channel first, then pulls its master line low.
// [R16] A low ISA master line drives AEN low.
// [R17] The block drives the refresh line low during its own refresh cycles.
// [R18] An owning ISA master drives refresh itself; the pin is then an input.
// [R19] AEN is high for DMA and refresh cycles, low at all other times.
// [R20] The DMA-owner strap is latched at board reset release and held.
`ifndef SBA_DEFS_SVH
`define SBA_DEFS_SVH
`define SBA_TIMER_DIV       4'hc
`define SBA_COPYBACK_CLKS   3'h4
`define SBA_RESET_HOLD_CLKS 8'h10
`define SBA_LOCAL_MASTERS   3
`endif

// File: logic/sba_pkg.sv
// Types for the bus arbitration and reset block.
package sba_pkg;
  typedef enum logic [2:0] {
    SBA_IDLE,
    SBA_HOLD_WAIT,
    SBA_OWN_LOCAL,
    SBA_OWN_DMA,
    SBA_OWN_REFRESH,
    SBA_RELEASE
  } sba_state_t;
endpackage : sba_pkg

// File: logic/sba_clk_if.sv
// Carrier between the arbiter top and its clock divider.
`timescale 1ns/1ps
interface sba_clk_if;
  logic       crystal_s;
  logic       dma_src_crystal;
  logic [1:0] dma_div_sel;
  logic       timer_tick;
  logic       dma_tick;
  modport gen (input crystal_s, input dma_src_crystal, input dma_div_sel,
               output timer_tick, output dma_tick);
  modport use_side (output crystal_s, output dma_src_crystal, output dma_div_sel,
                    input timer_tick, input dma_tick);
endinterface : sba_clk_if

// File: logic/sba_clkgen.sv
// Timer and DMA clock enables derived from the crystal and the processor clock.
`timescale 1ns/1ps
`include "sba_defs.svh"
module sba_clkgen (
  input wire logic clk,
  input wire logic rst_n,
  sba_clk_if.gen   ck
);
  logic       crystal_d_reg;
  logic       crystal_rise;
  logic [3:0] xtal_cnt_reg;
  logic [3:0] sclk_cnt_reg;
  logic [3:0] div_mask;
  logic       timer_tick_reg;
  logic       dma_tick_reg;

  assign crystal_rise = ck.crystal_s & ~crystal_d_reg;
  // Power-of-two divisions keep the select a plain mask: 2, 4, 8 or 16
  assign div_mask     = 4'((5'h02 << ck.dma_div_sel) - 5'h01);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crystal_d_reg <= 1'b0;
    end else begin
      crystal_d_reg <= ck.crystal_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xtal_cnt_reg   <= 4'h0;
      timer_tick_reg <= 1'b0;
    end else begin
      timer_tick_reg <= 1'b0;
      if (crystal_rise) begin
        if (xtal_cnt_reg == `SBA_TIMER_DIV - 4'h1) begin // [R1]
          xtal_cnt_reg   <= 4'h0;
          timer_tick_reg <= 1'b1;
        end else begin
          xtal_cnt_reg <= xtal_cnt_reg + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_cnt_reg <= 4'h0;
      dma_tick_reg <= 1'b0;
    end else begin
      sclk_cnt_reg <= sclk_cnt_reg + 4'h1;
      if (ck.dma_src_crystal) begin
        dma_tick_reg <= crystal_rise; // [R2]
      end else begin
        dma_tick_reg <= (sclk_cnt_reg & div_mask) == div_mask; // [R2]
      end
    end
  end

  assign ck.timer_tick = timer_tick_reg;
  assign ck.dma_tick   = dma_tick_reg;
endmodule : sba_clkgen

// File: logic/sba_top.sv
// Bus ownership arbiter and reset generator for the host bus.
`timescale 1ns/1ps
`include "sba_defs.svh"
module sba_top (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       crystal_in,
  output logic            crystal_out,
  input  wire logic       dma_src_crystal,
  input  wire logic [1:0] dma_div_sel,
  output logic            timer_clk_en,
  output logic            dma_clk_en,
  input  wire logic       supply_ok,
  input  wire logic       cpu_reset_req,
  output logic            processor_reset_out,
  output logic            board_wide_reset_out,
  output logic            bus_release_req,
  input  wire logic       bus_release_ack,
  input  wire logic [2:0] local_master_request_n,
  output logic [2:0]      local_master_grant_n,
  input  wire logic [2:0] local_pair_enable,
  input  wire logic       preempt_enable,
  input  wire logic       dma_request,
  output logic            dma_hold_ack,
  input  wire logic       refresh_request,
  output logic            refresh_ack,
  input  wire logic       dma_owner_n_in,
  output logic            dma_owner_n_out,
  output logic            dma_owner_n_oe,
  output logic            upper_sa_select,
  input  wire logic       copyback_window_n,
  output logic            address_float,
  input  wire logic       isa_master_n,
  output logic            aen,
  input  wire logic       refresh_n_in,
  output logic            refresh_n_out,
  output logic            refresh_n_oe
);
  sba_clk_if ck ();

  logic [1:0]          crystal_sync_reg;
  logic [1:0]          supply_sync_reg;
  logic [1:0]          copyback_sync_reg;
  logic [1:0]          master_sync_reg;
  logic [1:0]          strap_sync_reg;
  logic [5:0]          local_sync_reg;
  logic [2:0]          local_req;
  logic                copyback_d_reg;
  logic [2:0]          copyback_cnt_reg;
  logic                copyback_active;
  logic [7:0]          reset_cnt_reg;
  logic                cpu_reset_reg;
  logic                sys_reset_reg;
  logic                strap_reg;
  logic                hold_reg;
  logic [2:0]          grant_reg;
  logic [1:0]          owner_idx_reg;
  sba_pkg::sba_state_t state_reg;
  logic                any_req;
  logic                owner_done;
  logic                strap_phase;
  logic                dma_owner_n_reg;
  logic                aen_reg;
  logic                refresh_oe_reg;
  logic                float_reg;

  assign ck.crystal_s       = crystal_sync_reg[1];
  assign ck.dma_src_crystal = dma_src_crystal;
  assign ck.dma_div_sel     = dma_div_sel;

  sba_clkgen u_clkgen (
    .clk   (clk),
    .rst_n (rst_n),
    .ck    (ck)
  );

  assign timer_clk_en = ck.timer_tick;
  assign dma_clk_en   = ck.dma_tick;

  // Pin inputs from outside the clock domain pass two flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crystal_sync_reg  <= 2'h0;
      supply_sync_reg   <= 2'h0;
      copyback_sync_reg <= 2'h3;
      master_sync_reg   <= 2'h3;
      strap_sync_reg    <= 2'h3;
      local_sync_reg    <= 6'h3f;
    end else begin
      crystal_sync_reg  <= {crystal_sync_reg[0], crystal_in};
      supply_sync_reg   <= {supply_sync_reg[0], supply_ok};
      copyback_sync_reg <= {copyback_sync_reg[0], copyback_window_n};
      master_sync_reg   <= {master_sync_reg[0], isa_master_n};
      strap_sync_reg    <= {strap_sync_reg[0], dma_owner_n_in};
      local_sync_reg    <= {local_sync_reg[2:0], local_master_request_n};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crystal_out <= 1'b0;
    end else begin
      crystal_out <= crystal_sync_reg[1];
    end
  end

  // Unused pairs are masked so their floating pins cannot win
  genvar gi;
  generate
    for (gi = 0; gi < `SBA_LOCAL_MASTERS; gi++) begin : g_req
      assign local_req[gi] = ~local_sync_reg[3 + gi] & local_pair_enable[gi]; // [R9]
    end
  endgenerate

  // Reset generator: both resets on supply loss, processor reset alone on request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reset_cnt_reg <= `SBA_RESET_HOLD_CLKS;
      cpu_reset_reg <= 1'b1;
      sys_reset_reg <= 1'b1;
    end else if (!supply_sync_reg[1]) begin
      reset_cnt_reg <= `SBA_RESET_HOLD_CLKS;
      cpu_reset_reg <= 1'b1; // [R3]
      sys_reset_reg <= 1'b1; // [R4]
    end else if (cpu_reset_req && !cpu_reset_reg) begin
      reset_cnt_reg <= `SBA_RESET_HOLD_CLKS;
      cpu_reset_reg <= 1'b1; // [R3]
    end else if (reset_cnt_reg != 8'h00) begin
      reset_cnt_reg <= reset_cnt_reg - 8'h01;
    end else begin
      cpu_reset_reg <= 1'b0; // [R3]
      sys_reset_reg <= 1'b0; // [R4]
    end
  end

  assign processor_reset_out  = cpu_reset_reg;
  assign board_wide_reset_out = sys_reset_reg;
  assign strap_phase          = !supply_sync_reg[1] || sys_reset_reg; // [R12]

  // Strap is followed while in reset and frozen from release on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_reg <= 1'b1;
    end else if (strap_phase) begin
      strap_reg <= strap_sync_reg[1]; // [R20]
    end
  end

  assign upper_sa_select = strap_reg; // [R12]

  // Copyback window: falling edge starts a four clock hold drop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      copyback_d_reg   <= 1'b1;
      copyback_cnt_reg <= 3'h0;
    end else begin
      copyback_d_reg <= copyback_sync_reg[1];
      if (copyback_d_reg && !copyback_sync_reg[1]) begin
        copyback_cnt_reg <= `SBA_COPYBACK_CLKS; // [R13]
      end else if (copyback_cnt_reg != 3'h0) begin
        copyback_cnt_reg <= copyback_cnt_reg - 3'h1;
      end
    end
  end

  assign copyback_active = copyback_cnt_reg != 3'h0;
  assign any_req         = dma_request || refresh_request || (local_req != 3'h0);

  always_comb begin
    owner_done = 1'b0;
    unique case (state_reg)
      sba_pkg::SBA_OWN_LOCAL:   owner_done = !local_req[owner_idx_reg] ||
                                             (preempt_enable && dma_request); // [R10]
      sba_pkg::SBA_OWN_DMA:     owner_done = !dma_request;
      sba_pkg::SBA_OWN_REFRESH: owner_done = !refresh_request;
      default:                  owner_done = 1'b0;
    endcase
  end

  // Arbitration: refresh first, then DMA, then local masters 0 to 2
  always_ff @(posedge clk) begin
    if (!rst_n || strap_phase) begin
      state_reg     <= sba_pkg::SBA_IDLE;
      hold_reg      <= 1'b0;
      grant_reg     <= 3'h0;
      owner_idx_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        sba_pkg::SBA_IDLE: begin
          if (any_req) begin
            hold_reg  <= 1'b1; // [R5]
            state_reg <= sba_pkg::SBA_HOLD_WAIT;
          end
        end
        sba_pkg::SBA_HOLD_WAIT: begin
          // Acknowledge is already on this clock, so it is read directly
          if (bus_release_ack) begin // [R6]
            if (refresh_request) begin
              state_reg <= sba_pkg::SBA_OWN_REFRESH;
            end else if (dma_request) begin
              state_reg <= sba_pkg::SBA_OWN_DMA;
            end else if (local_req[0]) begin
              grant_reg     <= 3'h1; // [R7]
              owner_idx_reg <= 2'h0;
              state_reg     <= sba_pkg::SBA_OWN_LOCAL;
            end else if (local_req[1]) begin
              grant_reg     <= 3'h2; // [R7]
              owner_idx_reg <= 2'h1;
              state_reg     <= sba_pkg::SBA_OWN_LOCAL;
            end else if (local_req[2]) begin
              grant_reg     <= 3'h4; // [R7]
              owner_idx_reg <= 2'h2;
              state_reg     <= sba_pkg::SBA_OWN_LOCAL;
            end else begin
              hold_reg  <= 1'b0;
              state_reg <= sba_pkg::SBA_RELEASE;
            end
          end
        end
        sba_pkg::SBA_OWN_LOCAL,
        sba_pkg::SBA_OWN_DMA,
        sba_pkg::SBA_OWN_REFRESH: begin
          if (owner_done) begin
            grant_reg <= 3'h0; // [R10]
            // Keep the bus held when another party is already waiting
            state_reg <= sba_pkg::SBA_HOLD_WAIT;
          end
        end
        sba_pkg::SBA_RELEASE: begin
          if (!bus_release_ack) begin
            state_reg <= sba_pkg::SBA_IDLE;
          end
        end
      endcase
    end
  end

  assign bus_release_req      = hold_reg && !copyback_active; // [R13]
  assign local_master_grant_n = ~grant_reg; // [R8]
  assign dma_hold_ack         = state_reg == sba_pkg::SBA_OWN_DMA;
  assign refresh_ack          = state_reg == sba_pkg::SBA_OWN_REFRESH;

  // Pin drivers are registered so they change one clock after ownership
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dma_owner_n_reg <= 1'b1;
      aen_reg         <= 1'b0;
      refresh_oe_reg  <= 1'b0;
      float_reg       <= 1'b0;
    end else begin
      dma_owner_n_reg <= state_reg != sba_pkg::SBA_OWN_DMA; // [R11]
      aen_reg         <= (state_reg == sba_pkg::SBA_OWN_DMA ||
                          state_reg == sba_pkg::SBA_OWN_REFRESH) &&
                         master_sync_reg[1]; // [R16] [R19]
      refresh_oe_reg  <= state_reg == sba_pkg::SBA_OWN_REFRESH &&
                         master_sync_reg[1]; // [R17] [R18]
      float_reg       <= copyback_active &&
                         state_reg == sba_pkg::SBA_OWN_DMA; // [R14]
    end
  end

  assign dma_owner_n_out = dma_owner_n_reg;
  assign dma_owner_n_oe  = !strap_phase; // [R12]
  assign aen             = aen_reg;
  // Only the low level is ever driven; the bus pull-up gives the high level
  assign refresh_n_out   = 1'b0; // [R17]
  assign refresh_n_oe    = refresh_oe_reg;
  assign address_float   = float_reg;
endmodule : sba_top

// File: testbench/sba_top_sva.sv
// Port checker of the arbiter and reset block.
`timescale 1ns/1ps
module sba_top_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       supply_ok,
  input wire logic       processor_reset_out,
  input wire logic       board_wide_reset_out,
  input wire logic       bus_release_req,
  input wire logic [2:0] local_master_grant_n,
  input wire logic       dma_hold_ack,
  input wire logic       refresh_ack,
  input wire logic       dma_owner_n_out,
  input wire logic       dma_owner_n_oe,
  input wire logic       upper_sa_select,
  input wire logic       copyback_window_n,
  input wire logic       isa_master_n,
  input wire logic       aen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_one_grant: assert property ($onehot0(~local_master_grant_n))
    else $error("two grants low");
  a_copyback_low: assert property ($fell(copyback_window_n) |-> ##[1:5] !bus_release_req)
    else $error("hold not dropped for copyback");
  a_owner_low: assert property (dma_hold_ack |=> !dma_owner_n_out)
    else $error("owner pin high during dma");
  a_aen_idle: assert property (!dma_hold_ack && !refresh_ack |=> !aen)
    else $error("aen high outside dma and refresh");
  a_aen_isa: assert property (!isa_master_n [*4] |-> !aen)
    else $error("aen high with isa master");
  a_supply_reset: assert property (!supply_ok [*4] |->
    board_wide_reset_out && processor_reset_out)
    else $error("resets low while supply low");
  a_strap_held: assert property (!board_wide_reset_out && !$past(board_wide_reset_out) |->
    $stable(upper_sa_select))
    else $error("strap changed after reset");
  a_strap_input: assert property (board_wide_reset_out && $past(board_wide_reset_out) |->
    !dma_owner_n_oe)
    else $error("owner pin driven during reset");
  c_third_grant: cover property (!local_master_grant_n[2]);
  c_dma_copyback: cover property (dma_hold_ack && !copyback_window_n);
  c_reset_end: cover property ($fell(board_wide_reset_out));
endmodule : sba_top_chk

// File: testbench/sba_cpu_model.sv
// Processor model answering the bus-release handshake.
`timescale 1ns/1ps
module sba_cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic bus_release_req,
  output logic     bus_release_ack
);
  logic [1:0] ack_reg;
  // Changes only on clk, since the block reads it without a synchroniser
  always_ff @(posedge clk) begin
    if (!rst_n) ack_reg <= 2'h0;
    else ack_reg <= {ack_reg[0], bus_release_req};
  end
  assign bus_release_ack = slow ? ack_reg[1] : ack_reg[0];
endmodule : sba_cpu_model

// File: testbench/sba_test.sv
// Self-checking bench of the arbiter and reset block.
`timescale 1ns/1ps
module system_bus_arbitration_reset_test;
  logic clk, rst_n, crystal_in, dma_src_crystal, supply_ok, cpu_reset_req, preempt_enable;
  logic dma_request, refresh_request, copyback_window_n, isa_master_n, strap_n, slow;
  logic [1:0] dma_div_sel;
  logic [2:0] local_master_request_n, local_pair_enable, local_master_grant_n;
  logic crystal_out, timer_clk_en, dma_clk_en, processor_reset_out, board_wide_reset_out;
  logic bus_release_req, bus_release_ack, dma_hold_ack, refresh_ack, dma_owner_n_out;
  logic dma_owner_n_oe, upper_sa_select, address_float, aen, refresh_n_out, refresh_n_oe;
  wire  dma_owner_n_in, refresh_n_in;
  int   miscompares = 0;
  int   checks = 0;
  int   n;
  int   n_x = 0;
  logic f;
  assign dma_owner_n_in = dma_owner_n_oe ? dma_owner_n_out : strap_n;
  // Pull-up keeps refresh high while nobody drives it
  assign refresh_n_in = refresh_n_oe ? refresh_n_out : 1'b1;
  sba_top i_dut (.*);
  sba_cpu_model i_cpu (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Crystal stand-in, ten clocks a period
  always @(posedge clk) begin
    n_x <= (n_x == 4) ? 0 : n_x + 1;
    if (n_x == 4) crystal_in <= ~crystal_in;
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_grant(input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_grant
  task automatic chk_count(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_count
  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic meas(input bit tmr, input logic [7:0] exp);
    for (n = 0; n < 300 && (tmr ? timer_clk_en : dma_clk_en) !== 1'b1; n++) tick();
    n = 0;
    do begin tick(); n++; end while ((tmr ? timer_clk_en : dma_clk_en) !== 1'b1 && n < 300);
    chk_count(8'(n), exp);
  endtask : meas
  task automatic t_reset();
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    supply_ok <= 1'b1;
    n = 0;
    do begin tick(); n++; end while (board_wide_reset_out !== 1'b0 && n < 60);
    chk_count(8'(n >= 16 && n <= 22), 8'h01);
    chk_bit(processor_reset_out, 1'b0);
    chk_bit(upper_sa_select, 1'b0);
    @(posedge clk) strap_n <= 1'b1;
    repeat (4) tick();
    chk_bit(upper_sa_select, 1'b0);
    @(posedge clk) cpu_reset_req <= 1'b1;
    @(posedge clk) cpu_reset_req <= 1'b0;
    for (n = 0; n < 10 && processor_reset_out !== 1'b1; n++) tick();
    chk_bit(processor_reset_out, 1'b1);
    chk_bit(board_wide_reset_out, 1'b0);
    for (n = 0; n < 40 && processor_reset_out !== 1'b0; n++) tick();
    chk_bit(processor_reset_out, 1'b0);
    $display("t_reset done");
  endtask : t_reset
  // Mid-run supply loss: both resets, strap taken again with the other level
  task automatic t_supply();
    @(posedge clk) supply_ok <= 1'b0;
    repeat (8) tick();
    chk_bit(board_wide_reset_out, 1'b1);
    chk_bit(processor_reset_out, 1'b1);
    chk_bit(dma_owner_n_oe, 1'b0);
    @(posedge clk) supply_ok <= 1'b1;
    n = 0;
    do begin tick(); n++; end while (board_wide_reset_out !== 1'b0 && n < 60);
    chk_count(8'(n >= 16 && n <= 22), 8'h01);
    chk_bit(upper_sa_select, 1'b1);
    @(posedge clk) strap_n <= 1'b0;
    repeat (4) tick();
    chk_bit(upper_sa_select, 1'b1);
    $display("t_supply done");
  endtask : t_supply
  task automatic t_local();
    @(posedge clk) slow <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) local_master_request_n <= 3'(~(3'h1 << i));
      for (n = 0; n < 50 && local_master_grant_n[i] !== 1'b0; n++) tick();
      chk_grant(local_master_grant_n, 3'(~(3'h1 << i)));
      chk_bit(bus_release_req, 1'b1);
      chk_bit(aen, 1'b0);
      @(posedge clk) local_master_request_n <= 3'h7;
      for (n = 0; n < 50 && local_master_grant_n !== 3'h7; n++) tick();
      chk_grant(local_master_grant_n, 3'h7);
    end
    @(posedge clk) local_pair_enable <= 3'h3;
    local_master_request_n <= 3'h0;
    repeat (20) tick();
    chk_grant(local_master_grant_n, 3'h6);
    @(posedge clk) local_master_request_n <= 3'h3;
    repeat (20) tick();
    chk_grant(local_master_grant_n, 3'h7);
    @(posedge clk) local_pair_enable <= 3'h7;
    local_master_request_n <= 3'h7;
    slow <= 1'b0;
    repeat (10) tick();
    $display("t_local done");
  endtask : t_local
  task automatic t_dma();
    @(posedge clk) local_master_request_n <= 3'h6;
    for (n = 0; n < 50 && local_master_grant_n[0] !== 1'b0; n++) tick();
    @(posedge clk) dma_request <= 1'b1;
    repeat (10) tick();
    // Without preemption the local master keeps the bus
    chk_grant(local_master_grant_n, 3'h6);
    chk_bit(dma_hold_ack, 1'b0);
    @(posedge clk) preempt_enable <= 1'b1;
    for (n = 0; n < 50 && dma_hold_ack !== 1'b1; n++) tick();
    chk_grant(local_master_grant_n, 3'h7);
    tick();
    chk_bit(dma_owner_n_in, 1'b0);
    chk_bit(aen, 1'b1);
    @(posedge clk) copyback_window_n <= 1'b0;
    repeat (2) @(posedge clk);
    copyback_window_n <= 1'b1;
    f = 1'b0;
    for (n = 0; n < 10 && bus_release_req !== 1'b0; n++) tick();
    for (n = 0; n < 20 && bus_release_req === 1'b0; n++) begin
      f = f | address_float;
      tick();
    end
    chk_count(8'(n), 8'h04);
    chk_bit(f, 1'b1);
    // The ISA master takes over only while its DMA channel owns the bus
    @(posedge clk) isa_master_n <= 1'b0;
    repeat (6) tick();
    chk_bit(aen, 1'b0);
    chk_bit(dma_owner_n_in, 1'b0);
    @(posedge clk) isa_master_n <= 1'b1;
    dma_request <= 1'b0;
    local_master_request_n <= 3'h7;
    preempt_enable <= 1'b0;
    repeat (30) tick();
    chk_bit(aen, 1'b0);
    @(posedge clk) refresh_request <= 1'b1;
    for (n = 0; n < 50 && refresh_ack !== 1'b1; n++) tick();
    tick();
    chk_bit(refresh_n_in, 1'b0);
    chk_bit(aen, 1'b1);
    @(posedge clk) refresh_request <= 1'b0;
    repeat (20) tick();
    chk_bit(refresh_n_oe, 1'b0);
    $display("t_dma done");
  endtask : t_dma
  task automatic t_clocks();
    // Crystal output follows the crystal pin three clocks late
    repeat (4) begin
      f = crystal_in;
      repeat (3) tick();
      chk_bit(crystal_out, f);
      repeat (2) tick();
    end
    meas(1'b1, 8'd120);
    for (int s = 0; s < 5; s++) begin
      @(posedge clk) dma_div_sel <= 2'(s);
      dma_src_crystal <= (s == 4);
      repeat (30) tick();
      meas(1'b0, (s == 4) ? 8'd10 : 8'(2 << s));
    end
    $display("t_clocks done");
  endtask : t_clocks
  initial begin
    #400000;
    miscompares++;
    $display("ERROR t=%0t watchdog", $time);
    end_of_test();
  end
  initial begin
    {rst_n, crystal_in, dma_src_crystal, supply_ok, cpu_reset_req, preempt_enable} = '0;
    {dma_request, refresh_request, strap_n, slow, dma_div_sel} = '0;
    {copyback_window_n, isa_master_n} = 2'h3;
    local_master_request_n = 3'h7;
    local_pair_enable = 3'h7;
    t_reset();
    t_local();
    t_dma();
    t_supply();
    t_clocks();
    end_of_test();
  end
endmodule : system_bus_arbitration_reset_test
bind sba_top sba_top_chk i_chk (.*);
